// [core/bos_regs.svh]
// Register map, field positions, reset values and timing counts of the brown-out reset sequencer
`ifndef BOS_REGS_SVH
`define BOS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BOS_ADDR_W          12
`define BOS_OFF_CFG         12'h000
`define BOS_OFF_RSTCTL      12'h004
`define BOS_OFF_INT_STAT    12'h008
`define BOS_OFF_INT_MASK    12'h00C
`define BOS_OFF_OSC_STAT    12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BOS_CFG_OSCSEL_LSB  0
`define BOS_CFG_POSC_LSB    4
`define BOS_CFG_PUD_LSB     8
`define BOS_RSTCTL_FLAG_BIT 1
`define BOS_INT_BROWN_BIT   0
`define BOS_INT_REL_BIT     1
`define BOS_OSC_GATE_BIT    0
`define BOS_OSC_RST_BIT     1
`define BOS_OSC_STATE_LSB   2
`define BOS_OSC_LOCK_BIT    5
`define BOS_OSC_SRC_LSB     8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BOS_CFG_OSCSEL_RST  3'h2
`define BOS_CFG_POSC_RST    2'h1
`define BOS_CFG_PUD_RST     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BOS_CLK_PERIOD_NS   10
`define BOS_FAIL_MON_NS     100000
`define BOS_FAIL_MON_CYC    (`BOS_FAIL_MON_NS / `BOS_CLK_PERIOD_NS)
`define BOS_PUD_UNIT_NS     1000
`define BOS_PUD_UNIT_CYC    (`BOS_PUD_UNIT_NS / `BOS_CLK_PERIOD_NS)
`define BOS_OSU_CYC         1024
`define BOS_PULSE_CYC       4

`endif

// [core/bos_pkg.sv]
// Types shared by the brown-out reset sequencer
`default_nettype none
package bos_pkg;

  typedef enum logic [1:0] {
    BOS_RUN   = 2'b00,
    BOS_PULSE = 2'b01,
    BOS_WAIT  = 2'b10
  } bos_state_e;

  typedef enum logic [2:0] {
    BOS_SRC_FRC      = 3'b000,
    BOS_SRC_FRC_PLL  = 3'b001,
    BOS_SRC_PRI      = 3'b010,
    BOS_SRC_PRI_PLL  = 3'b011,
    BOS_SRC_SEC      = 3'b100,
    BOS_SRC_LPRC     = 3'b101
  } bos_src_e;

  typedef struct packed {
    bos_state_e  state;
    logic [3:0]  pulse_cnt;
    logic [2:0]  src_sel;
    logic        needs_osu;
    logic        needs_pll;
    logic [2:0]  osc_sel;
    logic [1:0]  posc_mode;
    logic [7:0]  pud;
    logic        flag;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;
    logic [31:0] prdata;
  } bos_state_s;

endpackage
`default_nettype wire

// [core/bos_timer.sv]
// Loadable down-counter used for the start-up and release delays
`default_nettype none
module bos_timer #(
  parameter int W = 20
) (
  input  wire logic         clock,   // System clock
  input  wire logic         rstn,    // Async reset, active low
  input  wire logic         start,   // Load pulse
  input  wire logic [W-1:0] load,    // Cycles to count
  output logic              done     // High once count reaches zero
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = load;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // A start in flight never reads as done
  assign done = (cnt_r == '0) && !start;

endmodule
`default_nettype wire

// [core/bos_clk_decode.sv]
// Decodes the clock-source configuration into start-up requirements
`default_nettype none
module bos_clk_decode
  import bos_pkg::*;
(
  input  wire logic [2:0] osc_sel,     // Oscillator select field
  input  wire logic [1:0] posc_mode,   // Primary oscillator mode field
  output logic            needs_osu,   // Source is an oscillator mode
  output logic            needs_pll,   // PLL in the clock path
  output logic            crystal      // Crystal on the primary oscillator
);

  logic pri;

  always_comb begin
    pri       = (osc_sel == BOS_SRC_PRI) || (osc_sel == BOS_SRC_PRI_PLL);
    // Mode 00 is an external clock and 11 disables the primary oscillator
    crystal   = pri && ((posc_mode == 2'h1) || (posc_mode == 2'h2));
    needs_osu = crystal || (osc_sel == BOS_SRC_SEC);
    needs_pll = (osc_sel == BOS_SRC_FRC_PLL) || (osc_sel == BOS_SRC_PRI_PLL);
  end

endmodule
`default_nettype wire

// [core/bos_seq.sv]
// Brown-out reset sequencer with APB register access
//
// Operation
// R1 - Brown-out pulses a reset into the whole device
// R2 - Clock source chosen from select and mode fields
// R3 - Oscillator modes wait for start-up timer expiry
// R4 - PLL paths hold clock until lock reads one
// R5 - Power-up delay runs alongside clock wait
// R6 - Zero delay with crystal uses fail-monitor delay
// R7 - Brown-out sets status flag bit one
// R8 - Detection stays active in Sleep and Idle
// R9 - Release needs both delay and clock ready
// R10 - Flag survives reset until software writes zero
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "bos_regs.svh"
`default_nettype none
module bos_seq
  import bos_pkg::*;
#(
  parameter int FAIL_MON_CYC = `BOS_FAIL_MON_CYC,
  parameter int PUD_UNIT_CYC = `BOS_PUD_UNIT_CYC,
  parameter int OSU_CYC      = `BOS_OSU_CYC,
  parameter int PULSE_CYC    = `BOS_PULSE_CYC,
  parameter int TW           = 20
) (
  input  wire logic                  clock,           // 100 MHz system clock
  input  wire logic                  rstn,            // Async reset, active low
  input  wire logic                  psel,            // APB select
  input  wire logic                  penable,         // APB enable
  input  wire logic                  pwrite,          // APB write
  input  wire logic [`BOS_ADDR_W-1:0] paddr,          // APB byte address
  input  wire logic [31:0]           pwdata,          // APB write data
  output logic      [31:0]           prdata,          // APB read data
  output logic                       pready,          // APB ready
  output logic                       pslverr,         // APB error on unmapped address
  input  wire logic                  brownout_det,    // Supply monitor below threshold
  input  wire logic                  pll_lock,        // PLL lock status
  output logic                       device_reset,    // Internal device reset, active high
  output logic                       sys_clk_enable,  // System clock gate
  output logic      [2:0]            clk_src_sel,     // Selected clock source
  output logic                       irq              // Level interrupt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam bos_state_s ST_RST = '{
    state:     BOS_PULSE,
    pulse_cnt: 4'h0,
    src_sel:   `BOS_CFG_OSCSEL_RST,
    needs_osu: 1'b0,
    needs_pll: 1'b0,
    osc_sel:   `BOS_CFG_OSCSEL_RST,
    posc_mode: `BOS_CFG_POSC_RST,
    pud:       `BOS_CFG_PUD_RST,
    flag:      1'b0,
    int_stat:  2'h0,
    int_mask:  2'h0,
    prdata:    32'h0000_0000
  };

  bos_state_s st;
  bos_state_s st_nxt;

  logic          dec_osu;
  logic          dec_pll;
  logic          dec_xtal;
  logic          osu_done;
  logic          dly_done;
  logic          tmr_start;
  logic [TW-1:0] dly_load;
  logic          clk_ready;
  logic          pulse_last;
  logic          bus_setup;
  logic          bus_wr;
  logic          addr_hit;
  logic          brown_event;
  logic          rel_event;
  logic          flag_clr;
  logic [1:0]    int_clr;
  logic [31:0]   rd_mux;

  // ----------------------------------------------------------------
  // Clock source decode and timers
  // ----------------------------------------------------------------
  bos_clk_decode u_decode (
    .osc_sel   (st.osc_sel),
    .posc_mode (st.posc_mode),
    .needs_osu (dec_osu),
    .needs_pll (dec_pll),
    .crystal   (dec_xtal)
  );

  bos_timer #(.W(TW)) u_osu_timer (
    .clock (clock),
    .rstn  (rstn),
    .start (tmr_start),
    .load  (TW'(OSU_CYC)),
    .done  (osu_done)
  );

  bos_timer #(.W(TW)) u_dly_timer (
    .clock (clock),
    .rstn  (rstn),
    .start (tmr_start),
    .load  (dly_load),
    .done  (dly_done)
  );

  // ----------------------------------------------------------------
  // Sequencing terms
  // ----------------------------------------------------------------
  always_comb begin
    pulse_last = (st.state == BOS_PULSE) && (st.pulse_cnt == 4'(PULSE_CYC - 1));
    // Timers start together so the delay overlaps the clock wait
    tmr_start  = pulse_last && !brownout_det; // R5
    if (st.pud != 8'h00) begin
      dly_load = TW'(st.pud * PUD_UNIT_CYC); // R5
    end else if (dec_xtal) begin
      dly_load = TW'(FAIL_MON_CYC); // R6
    end else begin
      dly_load = '0;
    end
    clk_ready = (!st.needs_osu || osu_done) // R3
             && (!st.needs_pll || pll_lock); // R4
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb begin
    bus_setup = psel && !penable;
    bus_wr    = psel && penable && pwrite;
    addr_hit  = (paddr == `BOS_OFF_CFG) || (paddr == `BOS_OFF_RSTCTL)
             || (paddr == `BOS_OFF_INT_STAT) || (paddr == `BOS_OFF_INT_MASK)
             || (paddr == `BOS_OFF_OSC_STAT);
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `BOS_OFF_CFG: begin
        rd_mux[`BOS_CFG_OSCSEL_LSB +: 3] = st.osc_sel;
        rd_mux[`BOS_CFG_POSC_LSB +: 2]   = st.posc_mode;
        rd_mux[`BOS_CFG_PUD_LSB +: 8]    = st.pud;
      end
      `BOS_OFF_RSTCTL: begin
        rd_mux[`BOS_RSTCTL_FLAG_BIT] = st.flag;
      end
      `BOS_OFF_INT_STAT: begin
        rd_mux[1:0] = st.int_stat;
      end
      `BOS_OFF_INT_MASK: begin
        rd_mux[1:0] = st.int_mask;
      end
      `BOS_OFF_OSC_STAT: begin
        rd_mux[`BOS_OSC_GATE_BIT]      = sys_clk_enable;
        rd_mux[`BOS_OSC_RST_BIT]       = device_reset;
        rd_mux[`BOS_OSC_STATE_LSB +: 2] = st.state;
        rd_mux[`BOS_OSC_LOCK_BIT]      = pll_lock;
        rd_mux[`BOS_OSC_SRC_LSB +: 3]  = st.src_sel;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st;
    brown_event = 1'b0;
    rel_event   = 1'b0;
    flag_clr    = bus_wr && addr_hit && (paddr == `BOS_OFF_RSTCTL) && !pwdata[`BOS_RSTCTL_FLAG_BIT];
    int_clr     = (bus_wr && (paddr == `BOS_OFF_INT_STAT)) ? pwdata[1:0] : 2'h0;

    // The detector path is never gated by Sleep or Idle
    unique case (st.state)
      BOS_RUN: begin
        if (brownout_det) begin
          st_nxt.state     = BOS_PULSE; // R1 R8
          st_nxt.pulse_cnt = 4'h0;
          brown_event      = 1'b1;
        end
      end
      BOS_PULSE: begin
        // Source is captured every pulse cycle so the last one wins
        st_nxt.src_sel   = st.osc_sel; // R2
        st_nxt.needs_osu = dec_osu; // R2
        st_nxt.needs_pll = dec_pll; // R2
        if (brownout_det) begin
          st_nxt.pulse_cnt = 4'h0; // R1
        end else if (pulse_last) begin
          st_nxt.state = BOS_WAIT;
        end else begin
          st_nxt.pulse_cnt = st.pulse_cnt + 4'h1;
        end
      end
      BOS_WAIT: begin
        if (brownout_det) begin
          st_nxt.state     = BOS_PULSE; // R1 R8
          st_nxt.pulse_cnt = 4'h0;
          brown_event      = 1'b1;
        end else if (clk_ready && dly_done) begin
          st_nxt.state = BOS_RUN; // R9
          rel_event    = 1'b1;
        end
      end
      default: begin
        st_nxt.state     = BOS_PULSE;
        st_nxt.pulse_cnt = 4'h0;
      end
    endcase

    // Set wins over a clear in the same cycle
    st_nxt.flag = (brownout_det || st.flag) && !(flag_clr && !brownout_det); // R7 R10
    st_nxt.int_stat[`BOS_INT_BROWN_BIT] = brown_event
                                       || (st.int_stat[`BOS_INT_BROWN_BIT] && !int_clr[`BOS_INT_BROWN_BIT]);
    st_nxt.int_stat[`BOS_INT_REL_BIT]   = rel_event
                                       || (st.int_stat[`BOS_INT_REL_BIT] && !int_clr[`BOS_INT_REL_BIT]);

    if (bus_wr && (paddr == `BOS_OFF_CFG)) begin
      st_nxt.osc_sel   = pwdata[`BOS_CFG_OSCSEL_LSB +: 3];
      st_nxt.posc_mode = pwdata[`BOS_CFG_POSC_LSB +: 2];
      st_nxt.pud       = pwdata[`BOS_CFG_PUD_LSB +: 8];
    end
    if (bus_wr && (paddr == `BOS_OFF_INT_MASK)) begin
      st_nxt.int_mask = pwdata[1:0];
    end
    // Read data is captured in the setup phase so prdata comes from a flop
    if (bus_setup) begin
      st_nxt.prdata = rd_mux;
    end
  end

  // Registers return to their reset values only on rstn, never on the reset they issue
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= ST_RST;
    end else begin
      st <= st_nxt; // R10
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign device_reset   = (st.state != BOS_RUN); // R1
  assign sys_clk_enable = (st.state == BOS_RUN) || ((st.state == BOS_WAIT) && clk_ready); // R3 R4
  assign clk_src_sel    = st.src_sel;
  assign irq            = |(st.int_stat & st.int_mask);
  assign prdata         = st.prdata;
  // No wait states: every access completes in its first access cycle
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !addr_hit;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pulse_to_wait;
    (st.state == BOS_PULSE) ##1 (st.state == BOS_WAIT);
  endsequence

  sequence s_pulse_entry;
    (st.state == BOS_RUN) && brownout_det;
  endsequence

  // Both release conditions met with the supply still good
  sequence s_release;
    (st.state == BOS_WAIT) && clk_ready && dly_done && !brownout_det;
  endsequence

  // A new sag while the clock wait is still running
  sequence s_restart;
    (st.state == BOS_WAIT) && brownout_det;
  endsequence

  chk_brownout_reset: assert property (@(posedge clock) disable iff (!rstn) // R1
    s_pulse_entry |=> device_reset [*4])
    else $error("Brown-out did not hold reset for the pulse");

  chk_src_latched: assert property (@(posedge clock) disable iff (!rstn) // R2
    s_pulse_to_wait |-> clk_src_sel == $past(st.osc_sel))
    else $error("Clock source not taken from configuration");

  chk_osu_gate: assert property (@(posedge clock) disable iff (!rstn) // R3
    (st.state == BOS_WAIT) && st.needs_osu && !osu_done |-> !sys_clk_enable)
    else $error("Clock enabled before start-up timer expiry");

  chk_pll_gate: assert property (@(posedge clock) disable iff (!rstn) // R4
    (st.state == BOS_WAIT) && st.needs_pll && !pll_lock |-> !sys_clk_enable)
    else $error("Clock enabled without PLL lock");

  chk_delay_hold: assert property (@(posedge clock) disable iff (!rstn) // R5
    (st.state == BOS_WAIT) && !dly_done |=> device_reset)
    else $error("Reset released before delay finished");

  chk_fail_delay: assert property (@(posedge clock) disable iff (!rstn) // R6
    tmr_start && (st.pud == 8'h00) && dec_xtal |-> dly_load == TW'(FAIL_MON_CYC))
    else $error("Fail-monitor delay not applied");

  chk_flag_set: assert property (@(posedge clock) disable iff (!rstn) // R7
    brownout_det |=> st.flag && device_reset)
    else $error("Brown-out flag not set");

  chk_release_both: assert property (@(posedge clock) disable iff (!rstn) // R9
    $fell(device_reset) |-> $past(clk_ready) && $past(dly_done))
    else $error("Reset released without both conditions");

  chk_flag_keep: assert property (@(posedge clock) disable iff (!rstn) // R10
    st.flag && !flag_clr |=> st.flag)
    else $error("Brown-out flag lost without software clear");

  chk_pulse_held: assert property (@(posedge clock) disable iff (!rstn) // R1
    (st.state == BOS_PULSE) |-> device_reset && !sys_clk_enable)
    else $error("Clock or reset wrong during the reset pulse");

  chk_restart_wait: assert property (@(posedge clock) disable iff (!rstn) // R8
    s_restart |=> (st.state == BOS_PULSE) && (st.pulse_cnt == 4'h0))
    else $error("Brown-out during clock wait did not restart the pulse");

  chk_src_hold: assert property (@(posedge clock) disable iff (!rstn) // R2
    (st.state != BOS_PULSE) |=> $stable(clk_src_sel))
    else $error("Clock source changed outside the reset pulse");

  chk_osu_start: assert property (@(posedge clock) disable iff (!rstn) // R3
    tmr_start |=> !osu_done)
    else $error("Start-up timer did not start");

  chk_delay_start: assert property (@(posedge clock) disable iff (!rstn) // R5
    tmr_start && (dly_load != TW'(0)) |=> !dly_done)
    else $error("Release delay did not start");

  chk_rel_status: assert property (@(posedge clock) disable iff (!rstn) // R9
    s_release |=> !device_reset && st.int_stat[`BOS_INT_REL_BIT])
    else $error("Reset not released once both conditions held");

  chk_flag_clear: assert property (@(posedge clock) disable iff (!rstn) // R10
    flag_clr && !brownout_det |=> !st.flag)
    else $error("Brown-out flag not cleared by software");

  chk_brown_int: assert property (@(posedge clock) disable iff (!rstn) // R7
    s_pulse_entry |=> st.int_stat[`BOS_INT_BROWN_BIT])
    else $error("Brown-out event not recorded");

  chk_pll_release: assert property (@(posedge clock) disable iff (!rstn) // R4
    $fell(device_reset) && st.needs_pll |-> $past(pll_lock))
    else $error("Reset released on a PLL path without lock");

endmodule
`default_nettype wire

// [tb/bos_supply_model.sv]
// Behavioural supply comparator and PLL lock source facing the sequencer
`default_nettype none
module bos_supply_model #(
  parameter int LOCK_CYC = 3
) (
  input  wire logic clock,         // System clock
  input  wire logic lock_en,       // PLL running on a good reference
  output logic      brownout_det,  // Supply below threshold
  output logic      pll_lock       // PLL locked
);
  timeunit 1ns;
  timeprecision 1ps;

  int   lock_cnt = 0;
  logic sag      = 1'b0;

  assign brownout_det = sag;

  // Lock drops at once when the PLL stops but needs settling time to return
  always @(posedge clock) begin
    lock_cnt <= !lock_en ? 0 : (lock_cnt < LOCK_CYC) ? lock_cnt + 1 : lock_cnt;
    pll_lock <= lock_en && (lock_cnt == LOCK_CYC);
  end

  // Supply sag lasting n clock cycles
  task automatic dip(input int n);
    @(posedge clock);
    sag <= 1'b1;
    repeat (n) @(posedge clock);
    sag <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/test_brownout_reset_sequencer.sv]
// Self-checking bench of the brown-out reset sequencer
`include "bos_regs.svh"
`default_nettype none
module test_brownout_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Shortened counts keep the run small
  // ----------------------------------------------------------------
  localparam int FAIL = 20;
  localparam int OSU = 8;
  localparam int UNIT = 2;
  localparam int PULSE = 4;

  logic        clock, rstn, psel, penable, pwrite, lock_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, brownout_det, pll_lock, device_reset, sys_clk_enable, irq, err;
  logic [2:0]  clk_src_sel;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  bos_seq #(.FAIL_MON_CYC(FAIL), .PUD_UNIT_CYC(UNIT), .OSU_CYC(OSU), .PULSE_CYC(PULSE)) i_dut (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .brownout_det(brownout_det),
    .pll_lock(pll_lock), .device_reset(device_reset), .sys_clk_enable(sys_clk_enable),
    .clk_src_sel(clk_src_sel), .irq(irq));

  bos_supply_model i_sup (.clock(clock), .lock_en(lock_en), .brownout_det(brownout_det), .pll_lock(pll_lock));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  // Counts cycles until the device leaves reset, giving up at lim
  task automatic wait_rel(input int lim, output int n);
    n = 0;
    while (device_reset !== 1'b0 && n < lim) begin
      tick;
      n++;
    end
  endtask

  task automatic brownout(input int lim, output int n);
    i_sup.dip(1);
    tick;
    chk(32'(device_reset), 32'h1);
    wait_rel(lim, n);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_powerup;
    chk(32'(clk_src_sel), 32'h2);
    chk(32'(device_reset), 32'h0);
    chk(32'(sys_clk_enable), 32'h1);
    chk(32'(pready), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b0, `BOS_OFF_CFG, 32'h0);
    chk(rd, 32'h0000_0012);
    apb(1'b0, `BOS_OFF_RSTCTL, 32'h0);
    chk(rd, 32'h0);
  endtask

  // Every source code except 3 (primary with PLL), with delays covering crystal, power-up delay and start-up timer
  task automatic test_sources;
    logic [11:0] cfg [6] = '{12'h012, 12'h800, 12'h034, 12'h001, 12'h005, 12'h002};
    int dly [6] = '{FAIL, 8 * UNIT, OSU, 0, 0, 0};
    int n;
    lock_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `BOS_OFF_RSTCTL, 32'h0);
      apb(1'b1, `BOS_OFF_CFG, {20'h0, cfg[i]});
      brownout(500, n);
      chk(32'(clk_src_sel), {29'h0, cfg[i][2:0]});
      chk(32'(n >= dly[i] + 2 && n <= dly[i] + PULSE + 8), 32'h1);
      chk(32'(sys_clk_enable), 32'h1);
      apb(1'b0, `BOS_OFF_RSTCTL, 32'h0);
      chk(rd, 32'h2);
    end
  endtask

  // Unlocked PLL keeps clock and reset held far beyond every delay
  task automatic test_pll_hold;
    int n;
    lock_en <= 1'b0;
    apb(1'b1, `BOS_OFF_CFG, 32'h0000_0513);
    brownout(60, n);
    chk(32'(device_reset), 32'h1);
    chk(32'(sys_clk_enable), 32'h0);
    apb(1'b0, `BOS_OFF_OSC_STAT, 32'h0);
    chk(rd, 32'h0000_030A);
    brownout(12, n);
    chk(32'(n), 32'h0000_000C);
    lock_en <= 1'b1;
    wait_rel(20, n);
    chk(32'(n < 20), 32'h1);
    chk(32'(clk_src_sel), 32'h3);
    apb(1'b0, `BOS_OFF_OSC_STAT, 32'h0);
    chk(rd, 32'h0000_0321);
  endtask

  task automatic test_regs;
    apb(1'b1, `BOS_OFF_RSTCTL, 32'h2);
    apb(1'b0, `BOS_OFF_RSTCTL, 32'h0);
    chk(rd, 32'h2);
    chk(32'(err), 32'h0);
    apb(1'b1, `BOS_OFF_RSTCTL, 32'h0);
    apb(1'b0, `BOS_OFF_RSTCTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `BOS_OFF_INT_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `BOS_OFF_INT_MASK, 32'h0);
    tick;
    chk(32'(irq), 32'h0);
    apb(1'b1, `BOS_OFF_INT_MASK, 32'h1);
    tick;
    chk(32'(irq), 32'h1);
    apb(1'b1, `BOS_OFF_INT_STAT, 32'h1);
    tick;
    chk(32'(irq), 32'h0);
    apb(1'b0, `BOS_OFF_INT_STAT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    int n;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lock_en = 1'b0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    wait_rel(2000, n);
    chk(32'(n >= FAIL + 2 && n <= FAIL + PULSE + 8), 32'h1);
    test_powerup;
    test_sources;
    test_pll_hold;
    test_regs;
    test_done;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
endmodule
`default_nettype wire
